// ===== core/spur_cancel_regs.vh
`ifndef SPUR_CANCEL_REGS_VH
`define SPUR_CANCEL_REGS_VH

// Register byte offsets on the plain register port
`define ADDR_W          8
`define REG_FTW         8'h00
`define REG_CTRL        8'h04
`define REG_CH0_CFG     8'h08
`define REG_CH1_CFG     8'h0C
`define REG_STATUS      8'h10

// Reset values
`define FTW_RST         32'h00000000
`define CTRL_RST        3'h0
`define CH_CFG_RST      22'h000000

// Control register fields
`define CTRL_EN0        0
`define CTRL_EN1        1
`define CTRL_CLR        2

// Channel configuration fields
`define CH_HARM_LSB     0
`define CH_HARM_MSB     3
`define CH_PHASE_LSB    4
`define CH_PHASE_MSB    12
`define CH_AMP_LSB      13
`define CH_AMP_MSB      20
`define CH_GAIN         21
`define CH_CFG_W        22

// Status register fields
`define ST_LEVEL_LSB    0
`define ST_LEVEL_MSB    4
`define ST_FULL         5
`define ST_EMPTY        6
`define ST_OUT_VALID    7

// Data path sizes and limits
`define DAC_W           14
`define FIFO_DEPTH      16
`define FIFO_AW         4
`define MIN_HARM        4'h2
`define SUM_MAX         16'h1FFF
`define SUM_MIN         16'hE000
`define DAC_POS_LIM     14'h1FFF
`define DAC_NEG_LIM     14'h2000

`endif

// ===== core/sample_fifo.v
`timescale 1ns/10ps
`default_nettype none

// Flip-flop FIFO between the main synthesizer and the combiner
module sample_fifo #(
    parameter WIDTH = 14,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    // Clock and reset
    input  wire             clk,
    input  wire             rst_n,
    // Filling side
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    // Draining side
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data,
    // Fill level
    output reg  [AW:0]      level
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];  // Storage, indexed by pointer
    reg [AW-1:0]    wr_ptr;           // Next slot to fill
    reg [AW-1:0]    rd_ptr;           // Oldest entry
    wire            push;
    wire            pop;

    // Full and empty come straight from the level count
    assign in_ready  = (level != DEPTH);
    assign out_valid = (level != 0);
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // Storage write, no reset needed for data
    always @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // Pointers and level
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            level  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            // Simultaneous push and pop leave the level alone
            if (push && !pop) begin
                level <= level + 1'b1;
            end else if (pop && !push) begin
                level <= level - 1'b1;
            end
        end
    end
endmodule // sample_fifo

`default_nettype wire

// ===== core/sine_lookup.v
`timescale 1ns/10ps
`default_nettype none

// Six-bit phase to signed eight-bit sine, quarter-wave table
module sine_lookup (
    // Phase in, one full turn over 64 steps
    input  wire [5:0] phase,
    // Signed sample, peak 127
    output wire [7:0] sample
);
    wire [3:0] idx;   // Index folded into the first quarter
    reg  [7:0] mag;   // Unsigned magnitude

    // Second and fourth quarters run the table backwards
    assign idx = phase[4] ? ~phase[3:0] : phase[3:0];

    // Half-step offset keeps the wave symmetric without a zero entry
    always @* begin
        case (idx)
            4'h0: mag = 8'h06;
            4'h1: mag = 8'h13;
            4'h2: mag = 8'h1F;
            4'h3: mag = 8'h2B;
            4'h4: mag = 8'h36;
            4'h5: mag = 8'h41;
            4'h6: mag = 8'h4C;
            4'h7: mag = 8'h55;
            4'h8: mag = 8'h5E;
            4'h9: mag = 8'h66;
            4'hA: mag = 8'h6D;
            4'hB: mag = 8'h73;
            4'hC: mag = 8'h78;
            4'hD: mag = 8'h7B;
            4'hE: mag = 8'h7E;
            default: mag = 8'h7F;
        endcase
    end

    // Second half of the turn is negative
    assign sample = phase[5] ? (8'h00 - mag) : mag;
endmodule // sine_lookup

`default_nettype wire

// ===== core/harmonic_spur_cancellation.v
// What this block does
// (R1) Two cancellation channels beside the main synthesizer
// (R2) Harmonic number selects second through fifteenth
// (R3) Nine-bit phase offset spans plus/minus pi
// (R4) Eight-bit amplitude scales each channel sinusoid
// (R5) Gain bit shifts scaled sample left once
// (R6) Gain clear: cancellation fits four low bits
// (R7) Cancellation added to main samples at converter
// (R8) Software picks harmonic after working out aliasing
// (R9) Channel phase steps by tuning word times harmonic
`timescale 1ns/10ps
`default_nettype none
`include "spur_cancel_regs.vh"

module harmonic_spur_cancellation (
    // Clock and reset
    input  wire                 clk,
    input  wire                 nrst,
    // Register port
    input  wire [`ADDR_W-1:0]   addr,
    input  wire [31:0]          wdata,
    input  wire                 wr,
    input  wire                 rd,
    output reg  [31:0]          rdata,
    // Main synthesizer samples, two's complement
    input  wire                 main_valid,
    output wire                 main_ready,
    input  wire [`DAC_W-1:0]    main_data,
    // Converter word out, two's complement
    output reg                  dac_valid,
    input  wire                 dac_ready,
    output reg  [`DAC_W-1:0]    dac_data
);
    // Reset synchroniser stages
    // Pin is asynchronous; these make release clean
    reg                         rst_meta;    // First stage only
    reg                         rst_n;       // Released reset copy

    // Software-visible state
    // All reset to zero: channels off, no tuning
    reg  [31:0]                 ftw;         // Main tuning word
    reg  [2:0]                  ctrl;        // Enables, clear strobe
    reg  [`CH_CFG_W-1:0]        cfg0;        // Channel 0 setup
    reg  [`CH_CFG_W-1:0]        cfg1;        // Channel 1 setup
    wire [2*`CH_CFG_W-1:0]      cfg_bus;     // Both setups, packed
    wire [1:0]                  ch_en;       // Channel enables
    wire                        phase_clr;   // One-cycle clear

    // Buffer between main synthesizer and combiner
    // Level feeds the status register only
    wire                        buf_valid;   // A sample is waiting
    wire                        buf_ready;   // Combiner takes it
    wire [`DAC_W-1:0]           buf_data;    // Oldest main sample
    wire [`FIFO_AW:0]           buf_level;   // Words held
    wire                        step;        // Sample consumed

    // Per-channel cancellation samples, signed five bits each
    // Channel 0 in bits 4:0, channel 1 in 9:5
    wire [9:0]                  cancel_bus;

    // Combiner arithmetic
    // All terms two's complement
    wire [15:0]                 main_ext;    // Main, sign-extended
    wire [15:0]                 c0_ext;      // Channel 0, extended
    wire [15:0]                 c1_ext;      // Channel 1, extended
    wire [15:0]                 sum;         // Raw total
    reg  [`DAC_W-1:0]           next_dac;    // Clamped total
    reg  [31:0]                 next_rdata;  // Read mux

    // Reset release through two flops; only the second is used
    // Assert is immediate, release waits two edges,
    // so all flops leave reset on the same edge.
    // Logic below resets from rst_n, not the pin.
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // Register writes; the clear bit is a self-clearing strobe
    // New setups apply from the next consumed sample.
    // Clear the accumulators after a harmonic change,
    // or the channel keeps the old phase it reached.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ftw  <= `FTW_RST;
            ctrl <= `CTRL_RST;
            cfg0 <= `CH_CFG_RST;
            cfg1 <= `CH_CFG_RST;
        end else begin
            // Strobe lasts a single cycle
            ctrl[`CTRL_CLR] <= 1'b0;
            if (wr) begin
                case (addr)
                    `REG_FTW: begin
                        ftw <= wdata;
                    end
                    `REG_CTRL: begin
                        ctrl <= wdata[2:0];
                    end
                    `REG_CH0_CFG: begin
                        cfg0 <= wdata[`CH_CFG_W-1:0];
                    end
                    `REG_CH1_CFG: begin
                        cfg1 <= wdata[`CH_CFG_W-1:0];
                    end
                    default: begin
                        // Unmapped writes are dropped
                    end
                endcase
            end
        end
    end

    // Setups packed so the generate loop slices them
    assign cfg_bus   = {cfg1, cfg0};
    assign ch_en     = ctrl[1:0];
    assign phase_clr = ctrl[`CTRL_CLR];

    // Read mux; unmapped offsets read as zero
    // Status is live at the strobe, not latched,
    // so the fill level may be one word stale.
    always @* begin
        next_rdata = 32'h00000000;
        case (addr)
            `REG_FTW: begin
                next_rdata = ftw;
            end
            `REG_CTRL: begin
                // Clear strobe always reads back low
                next_rdata[1:0] = ctrl[1:0];
            end
            `REG_CH0_CFG: begin
                next_rdata[`CH_CFG_W-1:0] = cfg0;
            end
            `REG_CH1_CFG: begin
                next_rdata[`CH_CFG_W-1:0] = cfg1;
            end
            `REG_STATUS: begin
                next_rdata[`ST_LEVEL_MSB:`ST_LEVEL_LSB] = buf_level;
                next_rdata[`ST_FULL]      = ~main_ready;
                next_rdata[`ST_EMPTY]     = ~buf_valid;
                next_rdata[`ST_OUT_VALID] = dac_valid;
            end
            default: begin
                next_rdata = 32'h00000000;
            end
        endcase
    end

    // Read data stands in the cycle after the strobe only
    // Zero between reads lets slaves share an or-bus
    // without further gating.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 32'h00000000;
        end else if (rd) begin
            rdata <= next_rdata;
        end else begin
            rdata <= 32'h00000000;
        end
    end

    // Main samples wait here; a stalled converter fills it up
    // Sixteen words ride out a short stall; longer
    // ones push back through main_ready.
    sample_fifo #(
        .WIDTH (`DAC_W),
        .DEPTH (`FIFO_DEPTH),
        .AW    (`FIFO_AW)
    ) u_fifo (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_valid  (main_valid),
        .in_ready  (main_ready),
        .in_data   (main_data),
        .out_valid (buf_valid),
        .out_ready (buf_ready),
        .out_data  (buf_data),
        .level     (buf_level)
    );

    // Take a sample when the output slot is free or being emptied
    // Channels move only with step, so a stall
    // keeps them aligned to the main samples.
    assign buf_ready = ~dac_valid | dac_ready;
    assign step      = buf_valid & buf_ready;

    // One cancellation channel per generate pass  (see R1)
    // Channels are identical and independent;
    // each targets a spur of its own.
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : g_ch
            wire [`CH_CFG_W-1:0] cfg;     // This channel's setup
            wire [3:0]           harm;    // Harmonic number
            wire [8:0]           poff;    // Phase offset
            wire [7:0]           amp;     // Amplitude
            wire                 gain;    // Doubling bit
            wire                 active;  // Enabled, valid harmonic
            wire [35:0]          prod;    // Tuning word times harmonic
            wire [31:0]          inc;     // Step, wrapped to 32 bits
            reg  [31:0]          acc;     // Phase accumulator
            wire [8:0]           ph;      // Offset phase
            wire [7:0]           sine;    // Signed sine sample
            wire [15:0]          scaled;  // Sine times amplitude
            wire [4:0]           base;    // Four-bit signed part
            wire [4:0]           out;     // After gain shift

            assign cfg  = cfg_bus[ch*`CH_CFG_W +: `CH_CFG_W];
            assign harm = cfg[`CH_HARM_MSB:`CH_HARM_LSB];
            assign poff = cfg[`CH_PHASE_MSB:`CH_PHASE_LSB];
            assign amp  = cfg[`CH_AMP_MSB:`CH_AMP_LSB];
            assign gain = cfg[`CH_GAIN];

            // Zero and one are not harmonics; channel stays silent
            // rather than adding DC or a main-tone copy
            assign active = ch_en[ch] & (harm >= `MIN_HARM); // see R2

            // Wraps modulo a full turn, which keeps phase exact
            // A harmonic past Nyquist aliases like the
            // spur, so the channel lands where it shows.
            assign prod = ftw * harm;                      // see R9
            assign inc  = prod[31:0];

            // Advances once per consumed main sample  (see R9)
            // Combiner uses the value before the update,
            // so a clear starts at phase zero plus offset.
            always @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    acc <= 32'h00000000;
                end else if (phase_clr) begin
                    acc <= 32'h00000000;
                end else if (step) begin
                    acc <= acc + inc;
                end
            end

            // Two's complement offset: 0x100 is a half turn  (see R3)
            // Low accumulator bits keep the rate exact
            // though only the top nine take the offset and six reach the table.
            assign ph = acc[31:23] + poff;

            sine_lookup u_sine (
                .phase  (ph[8:3]),
                .sample (sine)
            );

            // Signed times unsigned; the zero bit keeps amp positive
            // Peak 127*255 fits sixteen signed bits
            assign scaled = $signed(sine) * $signed({1'b0, amp}); // see R4

            // Top bits only: peak 127*255 lands at 7  (see R6)
            // Shift rounds toward minus infinity; a
            // one-LSB bias is far below the spur.
            assign base = {scaled[15], scaled[15:12]};

            // Gain doubles the swing but loses the lowest step
            // Five bits hold -16 to +14
            assign out = gain ? {base[3:0], 1'b0} : base;  // see R5

            // Disabled channel adds zero, not a frozen value
            assign cancel_bus[ch*5 +: 5] = active ? out : 5'h00;
        end
    endgenerate

    // Sign-extend all terms to a common width
    // Sixteen bits cannot wrap, so the clamp
    // below sees the true total.
    assign main_ext = {{2{buf_data[`DAC_W-1]}}, buf_data};
    assign c0_ext   = {{11{cancel_bus[4]}}, cancel_bus[4:0]};
    assign c1_ext   = {{11{cancel_bus[9]}}, cancel_bus[9:5]};
    assign sum      = main_ext + c0_ext + c1_ext;  // see R7

    // Clamp instead of wrapping, which would throw a full-scale spike
    // Near full scale cancellation is lost, but the
    // converter word stays sane.
    always @* begin
        if (!sum[15] && (sum > `SUM_MAX)) begin
            next_dac = `DAC_POS_LIM;
        end else if (sum[15] && (sum < `SUM_MIN)) begin
            next_dac = `DAC_NEG_LIM;
        end else begin
            next_dac = sum[`DAC_W-1:0];
        end
    end

    // Output slot holds the word until the converter takes it
    // Valid drops only when the last word is taken
    // and no sample waits behind it.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dac_valid <= 1'b0;
            dac_data  <= {`DAC_W{1'b0}};
        end else if (step) begin
            dac_valid <= 1'b1;
            dac_data  <= next_dac;                     // see R7
        end else if (dac_ready) begin
            dac_valid <= 1'b0;
        end
    end
endmodule // harmonic_spur_cancellation

`default_nettype wire

// ===== tb/dac_sink_model.sv
`timescale 1ns/10ps
`default_nettype none

// Converter input: takes words promptly, slowly, or not at all
module dac_sink_model (
    // Clock and reset
    input  wire logic clk,
    input  wire logic nrst,
    // Pace control from the bench
    input  wire logic hold,
    input  wire logic slow,
    // Word handshake
    input  wire logic dac_valid,
    output var  logic dac_ready
);
    // Ready changes only after an edge; slow mode halves the rate
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            dac_ready <= 1'b0;
        end else if (hold) begin
            // Long stall lets the sample buffer back up
            dac_ready <= 1'b0;
        end else begin
            dac_ready <= slow ? ~dac_ready : 1'b1;
        end
    end
endmodule // dac_sink_model

`default_nettype wire

// ===== tb/spur_cancel_assertions.sv
`timescale 1ns/10ps
`default_nettype none
`include "spur_cancel_regs.vh"

// Port-level checker for the spur cancellation block
module spur_cancel_assertions (
    // Clock and reset
    input wire logic                 clk,
    input wire logic                 nrst,
    // Register port
    input wire logic [`ADDR_W-1:0]   addr,
    input wire logic [31:0]          wdata,
    input wire logic                 wr,
    input wire logic                 rd,
    input wire logic [31:0]          rdata,
    // Sample streams
    input wire logic                 main_valid,
    input wire logic                 main_ready,
    input wire logic [`DAC_W-1:0]    main_data,
    input wire logic                 dac_valid,
    input wire logic                 dac_ready,
    input wire logic [`DAC_W-1:0]    dac_data
);
    logic [7:0]  in_cnt;   // Samples accepted
    logic [7:0]  out_cnt;  // Words delivered
    logic [21:0] cfg0_m;   // Shadow of channel 0 setup
    logic [1:0]  en_m;     // Shadow of channel enables
    wire  logic [7:0] pending;
    assign pending = in_cnt - out_cnt;

    // Shadows follow writes; counters bound what can be in flight
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            in_cnt  <= 8'h00;
            out_cnt <= 8'h00;
            cfg0_m  <= 22'h000000;
            en_m    <= 2'h0;
        end else begin
            if (main_valid && main_ready) in_cnt <= in_cnt + 8'h01;
            if (dac_valid && dac_ready) out_cnt <= out_cnt + 8'h01;
            if (wr && addr == `REG_CH0_CFG) cfg0_m <= wdata[21:0];
            if (wr && addr == `REG_CTRL) en_m <= wdata[1:0];
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    chk_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0)
        else $error("read data not zero outside a read");
    chk_unmapped_read: assert property (
        rd && addr > `REG_STATUS |=> rdata == 32'h0)
        else $error("unmapped read not zero");
    chk_status_read: assert property (rd && addr == `REG_STATUS |=>
        rdata[31:8] == 24'h0 && rdata[7] == $past(dac_valid)
        && rdata[5] == !$past(main_ready))
        else $error("status word wrong");
    chk_cfg_readback: assert property (
        rd && addr == `REG_CH0_CFG |=> rdata == {10'h0, cfg0_m})
        else $error("channel setup readback wrong");
    chk_ctrl_read: assert property (
        rd && addr == `REG_CTRL |=> rdata == {30'h0, en_m})
        else $error("control readback wrong");
    chk_dac_hold: assert property (
        dac_valid && !dac_ready |=> dac_valid && $stable(dac_data))
        else $error("converter word dropped or changed while stalled");
    chk_ready_drop: assert property ($fell(main_ready) |-> $past(main_valid))
        else $error("input refused without a fill");
    chk_full_refuse: assert property (!main_ready |-> pending >= 8'h10)
        else $error("input refused before buffer full");
    chk_pending_cap: assert property (pending <= 8'h11)
        else $error("more samples held than buffer allows");
    chk_out_source: assert property (dac_valid |-> pending != 8'h00)
        else $error("word offered with no sample behind it");

    cover property (!main_ready);
    cover property (dac_valid && !dac_ready ##1 dac_valid && dac_ready);
    cover property (rd && addr == `REG_STATUS);
endmodule // spur_cancel_assertions

bind harmonic_spur_cancellation spur_cancel_assertions u_chk (
    .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .main_valid(main_valid), .main_ready(main_ready),
    .main_data(main_data), .dac_valid(dac_valid), .dac_ready(dac_ready),
    .dac_data(dac_data));

`default_nettype wire

// ===== tb/tb_harmonic_spur_cancellation.sv
`timescale 1ns/10ps
`default_nettype none
`include "spur_cancel_regs.vh"
`define CHK(nm, e, g) begin n_tests++; if ((e) !== (g)) begin errors++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end

module tb_harmonic_spur_cancellation;
    // Quarter-wave sine, half-step offset
    localparam logic [7:0] QW [16] = '{8'h06, 8'h13, 8'h1F, 8'h2B, 8'h36,
        8'h41, 8'h4C, 8'h55, 8'h5E, 8'h66, 8'h6D, 8'h73, 8'h78, 8'h7B,
        8'h7E, 8'h7F};
    // Edge values force saturation both ways
    localparam logic [13:0] PAT [6] = '{14'h1FFF, 14'h2000, 14'h0000,
        14'h1234, 14'h3FF8, 14'h0007};
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        main_valid = 1'b0;
    logic [13:0] main_data = 14'h0;
    logic        hold = 1'b0;
    logic        slow = 1'b0;
    wire  logic [31:0] rdata;
    wire  logic        main_ready;
    wire  logic        dac_valid;
    wire  logic        dac_ready;
    wire  logic [13:0] dac_data;
    int          errors = 0;
    int          n_tests = 0;
    int          nsamp = 0;       // Samples since accumulators cleared
    logic [31:0] ftw = 32'h0;
    logic [1:0]  en = 2'h0;
    logic [21:0] cfg [2];
    logic [13:0] expq [$];        // Expected converter words in order
    logic [13:0] ex;

    harmonic_spur_cancellation DUT (.clk(clk), .nrst(nrst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .main_valid(main_valid), .main_ready(main_ready),
        .main_data(main_data), .dac_valid(dac_valid),
        .dac_ready(dac_ready), .dac_data(dac_data));
    dac_sink_model sink (.clk(clk), .nrst(nrst), .hold(hold), .slow(slow),
        .dac_valid(dac_valid), .dac_ready(dac_ready));

    // 50 MHz clock
    initial begin
        forever #10 clk = ~clk;
    end

    // One channel's contribution for sample k
    function automatic int chan(input logic [21:0] c, input int k);
        logic [31:0] acc;
        logic [8:0]  ph;
        logic [3:0]  i;
        int          s;
        int          r;
        acc = ftw * c[3:0] * k;
        ph = acc[31:23] + c[12:4];
        i = ph[7] ? 4'hF - ph[6:3] : ph[6:3];
        s = ph[8] ? -int'(QW[i]) : int'(QW[i]);
        r = (s * int'(c[20:13])) >>> 12;
        if (c[3:0] < 4'h2) r = 0;
        return c[21] ? r * 2 : r;
    endfunction

    // Main sample plus enabled channels, clamped to the converter
    function automatic logic [13:0] expect_word(input logic [13:0] d,
                                                input int k);
        int v;
        v = int'($signed(d));
        if (en[0]) v = v + chan(cfg[0], k);
        if (en[1]) v = v + chan(cfg[1], k);
        if (v > 8191) v = 8191;
        if (v < -8192) v = -8192;
        return v[13:0];
    endfunction

    task automatic stop_test;
        if (errors == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask

    // Data stand only in the cycle after the strobe
    task automatic rreg(input logic [7:0] a, input logic [31:0] e);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        `CHK("rdata", e, rdata)
    endtask

    // Offer one sample and hold it until taken
    task automatic push(input logic [13:0] d);
        int n;
        main_valid <= 1'b1;
        main_data <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (main_ready !== 1'b1 && n < 200);
        if (n >= 200) begin
            errors++;
            stop_test();
        end
        expq.push_back(expect_word(d, nsamp));
        nsamp++;
    endtask

    task automatic drain;
        int n;
        n = 0;
        while (expq.size() != 0 && n < 2000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 2000) begin
            errors++;
            stop_test();
        end
        @(posedge clk);
    endtask

    // Program everything and clear both accumulators while idle
    task automatic setup(input logic [1:0] e, input logic [21:0] c0,
                         input logic [21:0] c1, input logic [31:0] f);
        en = e;
        cfg[0] = c0;
        cfg[1] = c1;
        ftw = f;
        wreg(`REG_FTW, f);
        wreg(`REG_CH0_CFG, {10'h0, c0});
        wreg(`REG_CH1_CFG, {10'h0, c1});
        wreg(`REG_CTRL, {29'h0, 1'b1, e});
        nsamp = 0;
    endtask

    task automatic stream;
        for (int i = 0; i < 6; i++) push(PAT[i]);
        main_valid <= 1'b0;
        drain();
    endtask

    // Every word the converter takes is checked in order
    always @(posedge clk) begin
        if (dac_valid === 1'b1 && dac_ready === 1'b1) begin
            if (expq.size() == 0) begin
                `CHK("extra word", 1'b0, 1'b1)
            end else begin
                ex = expq.pop_front();
                `CHK("dac_data", ex, dac_data)
            end
        end
    end

    initial begin
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        // Reset values, unmapped places, field widths, read-only status
        rreg(`REG_FTW, 32'h0);
        rreg(`REG_CTRL, 32'h0);
        rreg(`REG_CH0_CFG, 32'h0);
        rreg(`REG_CH1_CFG, 32'h0);
        rreg(`REG_STATUS, 32'h40);
        rreg(8'h14, 32'h0);
        rreg(8'hFC, 32'h0);
        wreg(`REG_CH1_CFG, 32'hFFFFFFFF);
        rreg(`REG_CH1_CFG, 32'h003FFFFF);
        wreg(`REG_CTRL, 32'hFFFFFFFF);
        rreg(`REG_CTRL, 32'h3);
        wreg(`REG_STATUS, 32'h0);
        rreg(`REG_STATUS, 32'h40);
        // Channels off: plain pass-through
        setup(2'b00, 22'h3FFFFF, 22'h3FFFFF, 32'h12345678);
        stream();
        // Each channel alone
        for (int e = 1; e < 3; e++) begin
            setup(2'(e), 22'h3FE017, 22'h1FE12F, 32'h0B3A1C47);
            stream();
        end
        // Every harmonic number, phases, amplitudes and gain
        for (int h = 0; h < 16; h++) begin
            setup(2'b11, {h[0], 8'hFF, 9'(h * 37), 4'(h)},
                {~h[0], 8'(h * 16 + 15), 9'h100, 4'(15 - h)}, 32'h0B3A1C47);
            stream();
        end
        // Converter stalled: fill until refused, then drain slowly
        hold <= 1'b1;
        setup(2'b11, 22'h3FE0A5, 22'h1FE033, 32'h7654321F);
        main_valid <= 1'b1;
        main_data <= 14'h0;
        for (int i = 0; i < 40; i++) begin
            @(posedge clk);
            if (main_ready === 1'b1) begin
                expq.push_back(expect_word(main_data, nsamp));
                nsamp++;
                main_data <= main_data + 14'h0111;
            end
        end
        main_valid <= 1'b0;
        `CHK("main_ready", 1'b0, main_ready)
        rreg(`REG_STATUS, 32'hB0);
        slow <= 1'b1;
        hold <= 1'b0;
        drain();
        rreg(`REG_STATUS, 32'h40);
        stop_test();
    end
endmodule // tb_harmonic_spur_cancellation

`default_nettype wire
